// ### verilog/ahri_pkg.sv
// constants, field layout and state type of the converter host register interface
// assumes one 25 MHz clock and a processor bus sampled synchronously to it
package ahri_pkg;

  // ==========================================================================
  // bus address decode (A1, A0)
  localparam logic [1:0] ADDR_CONTROL      = 2'h0;
  localparam logic [1:0] ADDR_RESULT_UPPER = 2'h1;
  localparam logic [1:0] ADDR_TEST         = 2'h3;
  localparam int         ADDR_LOWER_BIT    = 1;

  // ==========================================================================
  // control byte and status byte fields
  localparam int CTRL_CHAN_LSB   = 0;
  localparam int CTRL_CHAN_MSB   = 1;
  localparam int CTRL_FLAG_BIT   = 2;
  localparam int CTRL_RES_BIT    = 3;
  localparam int CTRL_LOW_MSB    = 3;
  localparam int STAT_EOC_BIT    = 7;
  localparam int STAT_BUSY_BIT   = 6;
  localparam int STAT_RES_HI_BIT = 5;
  localparam int STAT_RES_LO_BIT = 4;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [11:0] RESULT_RESET  = 12'h000;
  localparam logic [3:0]  LOW_NIBBLE_ZERO = 4'h0;
  localparam logic [7:0]  BUS_IDLE      = 8'h00;

  // ==========================================================================
  // conversion timing (typical times, microseconds)
  localparam int CLK_FREQ_MHZ     = 25;
  localparam int CONV8_TIME_US    = 4000;
  localparam int CONV12_TIME_US   = 10000;
  localparam int CONV8_CYCLES_DEF  = CONV8_TIME_US * CLK_FREQ_MHZ;
  localparam int CONV12_CYCLES_DEF = CONV12_TIME_US * CLK_FREQ_MHZ;
  localparam int COUNT_W          = 18;

  typedef enum logic [1:0] {
    AHRI_IDLE,
    AHRI_CONVERT,
    AHRI_TEST
  } ahri_state_t;

endpackage : ahri_pkg

// ### verilog/ahri_top.sv
// processor-side control and register logic of a four-channel integrating converter
// assumes bus pins synchronous to mclk; the analog front end supplies conv_sample
`timescale 1ns/1ps
module ahri_top
  import ahri_pkg::*;
#(
  parameter int unsigned CONV8_CYCLES  = CONV8_CYCLES_DEF,
  parameter int unsigned CONV12_CYCLES = CONV12_CYCLES_DEF
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [1:0]  addr,
  input  wire logic [7:0]  data_in,
  input  wire logic [11:0] conv_sample,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic      [1:0]  channel_select,
  output logic             eoc_n
);

  // ==========================================================================
  // bus sampling
  logic              cs_n_q;
  logic              wr_n_q;
  logic [1:0]        addr_q;
  logic [7:0]        data_q;
  logic [7:0]        control;
  logic [11:0]       result;
  logic              busy;
  logic [COUNT_W-1:0] conv_count;
  logic [COUNT_W-1:0] next_count;
  ahri_state_t       state;
  ahri_state_t       next_state;
  logic              wr_done;
  logic              ctrl_wr;
  logic              test_wr;
  logic              conv_done;
  logic              rd_act;
  logic [7:0]        next_data;

  // the write is taken at the end of the strobe, where data setup is guaranteed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      addr_q <= ADDR_CONTROL;
      data_q <= BUS_IDLE;
    end else begin
      cs_n_q <= cs_n;
      wr_n_q <= wr_n;
      addr_q <= addr;
      data_q <= data_in;
    end
  end

  assign wr_done = !wr_n_q && wr_n && !cs_n_q;
  assign ctrl_wr = wr_done && (addr_q == ADDR_CONTROL);
  assign test_wr = wr_done && (addr_q == ADDR_TEST);
  assign conv_done = (state == AHRI_CONVERT) && (conv_count == '0) && !ctrl_wr && !test_wr;
  assign rd_act  = !cs_n && !rd_n && wr_n;

  // ==========================================================================
  // control register and channel multiplexer select
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control        <= CONTROL_RESET;
      channel_select <= CONTROL_RESET[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
    end else if (ctrl_wr) begin
      control        <= data_q;
      channel_select <= data_q[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
    end
  end

  // ==========================================================================
  // sequencer: a new control write always wins, even mid-conversion
  always_comb begin
    next_state = state;
    next_count = conv_count;
    case (state)
      AHRI_IDLE: begin
        if (test_wr) begin
          next_state = AHRI_TEST;
        end
      end
      AHRI_CONVERT: begin
        if (test_wr) begin
          next_state = AHRI_TEST;
        end else if (conv_count == '0) begin
          next_state = AHRI_IDLE;
        end else begin
          next_count = conv_count - COUNT_W'(1);
        end
      end
      AHRI_TEST: begin
        next_state = AHRI_TEST;
      end
      default: begin
        next_state = AHRI_IDLE;
      end
    endcase
    if (test_wr) begin
      next_count = {conv_count[COUNT_W-1:8], data_q};
    end
    if (ctrl_wr) begin
      next_state = AHRI_CONVERT;
      next_count = data_q[CTRL_RES_BIT] ? COUNT_W'(CONV12_CYCLES - 1)
                                        : COUNT_W'(CONV8_CYCLES - 1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= AHRI_IDLE;
      conv_count <= '0;
    end else begin
      state      <= next_state;
      conv_count <= next_count;
    end
  end

  // ==========================================================================
  // busy and end of conversion; a start in the same cycle cannot coincide with done
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy  <= 1'b0;
      eoc_n <= 1'b1;
    end else if (ctrl_wr) begin
      busy  <= 1'b1;
      eoc_n <= 1'b1;
    end else if (conv_done) begin
      busy  <= 1'b0;
      eoc_n <= 1'b0;
    end
  end

  // an 8-bit conversion leaves the lower nibble at zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result <= RESULT_RESET;
    end else if (conv_done) begin
      result <= control[CTRL_RES_BIT] ? conv_sample
                                      : {conv_sample[11:4], LOW_NIBBLE_ZERO};
    end
  end

  // ==========================================================================
  // read path; data bus is released whenever no valid read is under way
  always_comb begin
    if (addr == ADDR_CONTROL) begin
      next_data = {eoc_n, !busy, result[11:10], control[CTRL_LOW_MSB:0]};
    end else if (addr == ADDR_RESULT_UPPER) begin
      next_data = result[11:4];
    end else begin
      next_data = {result[3:0], LOW_NIBBLE_ZERO};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_oe  <= 1'b0;
      data_out <= BUS_IDLE;
    end else begin
      data_oe  <= rd_act;
      data_out <= rd_act ? next_data : BUS_IDLE;
    end
  end

  // ==========================================================================
  // checks
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  start_latch_a: assert property (ctrl_wr |=> control == $past(data_q))
    else $error("control byte not latched on write");

  start_busy_a: assert property (ctrl_wr |=> busy && eoc_n && state == AHRI_CONVERT)
    else $error("control write did not start a conversion");

  chan_route_a: assert property (ctrl_wr |=> ##1
                                 channel_select == $past(data_q[CTRL_CHAN_MSB:CTRL_CHAN_LSB], 2))
    else $error("channel select does not follow control bits");

  res_length_a: assert property (ctrl_wr && !data_q[CTRL_RES_BIT]
                                 |=> conv_count == COUNT_W'(CONV8_CYCLES - 1))
    else $error("8-bit conversion length wrong");

  res_long_a: assert property (ctrl_wr && data_q[CTRL_RES_BIT]
                               |=> conv_count == COUNT_W'(CONV12_CYCLES - 1))
    else $error("12-bit conversion length wrong");

  eoc_done_a: assert property (conv_done |=> !eoc_n && !busy
                               && result[11:4] == $past(conv_sample[11:4]))
    else $error("completion did not raise end of conversion");

  eoc_hold_a: assert property (!eoc_n && !ctrl_wr |=> !eoc_n)
    else $error("end of conversion dropped without a new start");

  read_nodisturb_a: assert property (rd_act && state == AHRI_CONVERT
                                     && conv_count != '0 && !ctrl_wr && !test_wr
                                     |=> state == AHRI_CONVERT
                                     && conv_count == $past(conv_count) - COUNT_W'(1))
    else $error("status read disturbed the conversion");

  status_map_a: assert property (rd_act && addr == ADDR_CONTROL
                                 |=> data_oe && data_out == {$past(eoc_n), !$past(busy),
                                 $past(result[11:10]), $past(control[3:0])})
    else $error("status byte layout wrong");

  // the earliest status read after a control write is sampled two edges after it is taken
  flag_echo_a: assert property (ctrl_wr ##2
                                (rd_act && addr == ADDR_CONTROL && !wr_done)
                                |=> data_out[CTRL_FLAG_BIT] == $past(data_q[CTRL_FLAG_BIT], 3))
    else $error("flag bit not echoed in status");

  upper_byte_a: assert property (rd_act && addr == ADDR_RESULT_UPPER
                                 |=> data_out == $past(result[11:4]))
    else $error("upper result byte wrong");

  lower_byte_a: assert property (rd_act && addr[ADDR_LOWER_BIT]
                                 |=> data_out == {$past(result[3:0]), 4'h0})
    else $error("lower result byte wrong");

  test_entry_a: assert property (test_wr && !ctrl_wr
                                 |=> state == AHRI_TEST && conv_count[7:0] == $past(data_q))
    else $error("test write did not load the counter");

  bus_quiet_a: assert property (cs_n |=> !data_oe && data_out == BUS_IDLE)
    else $error("data bus driven while deselected");

  // a completion may legally coincide with an ignored write, so it is left out here
  unused_wr_a: assert property (wr_done && (addr_q == 2'h1 || addr_q == 2'h2)
                                && !conv_done |=> $stable(control) && state == $past(state))
    else $error("write to unused address had an effect");

  // holding checks: each register may move only on the event that owns it, so a stray
  // enable shows up here long before it corrupts a later read
  busy_idle_a: assert property (state == AHRI_IDLE |-> !busy)
    else $error("busy set while idle");

  conv_busy_a: assert property (state == AHRI_CONVERT |-> busy)
    else $error("conversion running without busy");

  eoc_busy_a: assert property (!eoc_n |-> !busy)
    else $error("end of conversion shown while busy");

  eoc_rise_a: assert property ($rose(eoc_n) |-> $past(ctrl_wr))
    else $error("end of conversion cleared without a control write");

  eoc_fall_a: assert property ($fell(eoc_n) |-> $past(conv_done))
    else $error("end of conversion raised without a completion");

  chan_hold_a: assert property (!ctrl_wr |=> $stable(channel_select))
    else $error("channel select moved without a control write");

  ctrl_hold_a: assert property (!ctrl_wr |=> $stable(control))
    else $error("control byte moved without a control write");

  result_hold_a: assert property (!conv_done |=> $stable(result))
    else $error("result moved without a completion");

  low_nibble_a: assert property (conv_done && !control[CTRL_RES_BIT]
                                 |=> result[3:0] == LOW_NIBBLE_ZERO)
    else $error("8-bit result has a nonzero lower nibble");

  full_result_a: assert property (conv_done && control[CTRL_RES_BIT]
                                  |=> result == $past(conv_sample))
    else $error("12-bit result not taken whole");

  test_freeze_a: assert property (state == AHRI_TEST && !test_wr && !ctrl_wr
                                  |=> state == AHRI_TEST && $stable(conv_count))
    else $error("test mode counter did not hold");

  test_keep_a: assert property (test_wr |=> $stable(busy) && $stable(eoc_n))
    else $error("test write changed busy or end of conversion");

  read_keep_a: assert property (rd_act && !wr_done && !conv_done
                                |=> $stable(control) && $stable(busy))
    else $error("read changed the converter state");

  oe_follow_a: assert property (rd_act |=> data_oe)
    else $error("read did not drive the data bus");

  read_release_a: assert property (!rd_act |=> !data_oe && data_out == BUS_IDLE)
    else $error("data bus driven with no read");

  unused_keep_a: assert property (wr_done && (addr_q == 2'h1 || addr_q == 2'h2)
                                  && !conv_done
                                  |=> $stable(busy) && $stable(eoc_n) && $stable(channel_select))
    else $error("write to unused address changed status");

  conv_end_c: cover property (state == AHRI_CONVERT ##1 state == AHRI_IDLE && !eoc_n);
  read_busy_c: cover property (rd_act && busy && addr == ADDR_CONTROL);
  restart_c: cover property (state == AHRI_CONVERT && ctrl_wr);
  test_c: cover property (test_wr ##[1:100] ctrl_wr);
  short_conv_c: cover property (conv_done && !control[CTRL_RES_BIT]);

endmodule : ahri_top

// ### test/ahri_cpu_model.sv
// processor side of the converter bus: strobes, address and the data bus wire
// assumes the device answers a read one cycle after it samples the strobe
`timescale 1ns/1ps
module ahri_cpu_model (
  input  wire logic       mclk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [1:0]      addr,
  output logic [7:0]      data_in
);
  logic [7:0] drv;
  logic       drv_en;

  // ==========
  // bus wire
  // a released bus shows the inverse of the last level, so stale data cannot pass
  always_comb data_in = data_oe ? data_out : (drv_en ? drv : ~drv);

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 2'h0;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  // ==========
  // bus cycles
  task automatic bus_write(input logic [1:0] a, input logic [7:0] d, input logic sel_n);
    @(posedge mclk);
    #1;
    cs_n = sel_n;
    addr = a;
    drv = d;
    drv_en = 1'b1;
    wr_n = 1'b0;
    @(posedge mclk);
    #1 wr_n = 1'b1;
    // hold address and data until the edge that sees the strobe high
    @(posedge mclk);
    #1;
    cs_n = 1'b1;
    drv_en = 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [1:0] a, output logic [7:0] d, output logic oe);
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    addr = a;
    rd_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    d = data_in;
    oe = data_oe;
    @(posedge mclk);
    #1;
    rd_n = 1'b1;
    cs_n = 1'b1;
  endtask : bus_read
endmodule : ahri_cpu_model

// ### test/tb_top.sv
// self-checking bench of the converter host register interface
// assumes ahri_cpu_model drives the bus and conv_sample stands in for the integrator
`timescale 1ns/1ps
module tb_top;
  import ahri_pkg::*;
  // short counts keep the run brief
  localparam int C8  = 20;
  localparam int C12 = 50;
  logic        mclk, reset_n, cs_n, rd_n, wr_n, data_oe, eoc_n;
  logic [1:0]  addr, channel_select;
  logic [7:0]  data_in, data_out, rd;
  logic [11:0] conv_sample, res;
  int          err_count, n_checks;

  ahri_top #(.CONV8_CYCLES(C8), .CONV12_CYCLES(C12)) ahri_top_inst (
    .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .conv_sample(conv_sample), .data_out(data_out),
    .data_oe(data_oe), .channel_select(channel_select), .eoc_n(eoc_n));
  ahri_cpu_model ahri_cpu_model_inst (
    .mclk(mclk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // ==========
  // helpers
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic get(input logic [1:0] a);
    logic oe;
    ahri_cpu_model_inst.bus_read(a, rd, oe);
    check(oe, 1'b1);
    @(posedge mclk);
    #1 check(data_oe, 1'b0);
  endtask : get

  task automatic run_conv(input logic [7:0] c, input logic [11:0] s);
    int n;
    int lim;
    logic [11:0] r;
    lim = c[3] ? C12 : C8;
    r = c[3] ? s : {s[11:4], 4'h0};
    conv_sample = s;
    ahri_cpu_model_inst.bus_write(2'h0, c, 1'b0);
    check(channel_select, c[1:0]);
    get(2'h0);
    check(rd, {2'b10, res[11:10], c[3:0]});
    // five edges have passed since the write was taken
    n = 5;
    while (eoc_n !== 1'b0 && n < lim + 9) begin
      @(posedge mclk);
      #1 n++;
    end
    check(n >= lim && n <= lim + 2, 1'b1);
    res = r;
    get(2'h0);
    check(rd, {2'b01, r[11:10], c[3:0]});
    get(2'h1);
    check(rd, r[11:4]);
    get(2'h2);
    check(rd, {r[3:0], 4'h0});
    get(2'h3);
    check(rd, {r[3:0], 4'h0});
  endtask : run_conv

  // ==========
  // tests
  initial begin
    reset_n = 1'b0;
    conv_sample = 12'h000;
    res = 12'h000;
    err_count = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    check(eoc_n, 1'b1);
    get(2'h0);
    check(rd, 8'hC0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      run_conv(8'(i * 5), 12'hA53 + 12'(i * 291));
    end
    $display("test channels done");
    ahri_cpu_model_inst.bus_write(2'h1, 8'h0E, 1'b0);
    ahri_cpu_model_inst.bus_write(2'h2, 8'h0E, 1'b0);
    ahri_cpu_model_inst.bus_write(2'h0, 8'h0E, 1'b1);
    check(channel_select, 2'h3);
    get(2'h0);
    check(rd, {2'b01, res[11:10], 4'hF});
    $display("test ignored writes done");
    ahri_cpu_model_inst.bus_write(2'h0, 8'h09, 1'b0);
    repeat (10) @(posedge mclk);
    run_conv(8'h06, 12'h5E7);
    $display("test restart done");
    ahri_cpu_model_inst.bus_write(2'h0, 8'h08, 1'b0);
    ahri_cpu_model_inst.bus_write(2'h3, 8'h5A, 1'b0);
    repeat (C12 + 10) @(posedge mclk);
    #1 check(eoc_n, 1'b1);
    // results after test mode are only trusted after a fresh conversion
    run_conv(8'h0B, 12'hFFF);
    $display("test mode done");
    report_and_stop();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
endmodule : tb_top
